// File: rtl/dibe_consts.svh
// register indices, field positions, reset values and step counts of the DES block engine
`ifndef DIBE_CONSTS_SVH
`define DIBE_CONSTS_SVH
`define DIBE_CTRL_IDX 8'hc3
`define DIBE_KEYLOC_IDX 8'hc4
`define DIBE_DATLOC_IDX 8'hc5
`define DIBE_COUNT_IDX 8'hc6
`define DIBE_IV0_IDX 8'hb4
`define DIBE_IV4_IDX 8'hbc
`define DIBE_IRQ_STAT_IDX 8'hc8
`define DIBE_IRQ_CLR_IDX 8'hc9
`define DIBE_IRQ_EN_IDX 8'hca
`define DIBE_BIT_RUN 0
`define DIBE_BIT_RSVD 1
`define DIBE_BIT_DIR 2
`define DIBE_BIT_MODE 3
`define DIBE_BIT_KEYLD 4
`define DIBE_BIT_DONE 5
`define DIBE_BIT_IE 6
`define DIBE_BIT_IRQ 0
`define DIBE_BIT_RST 1'b0
`define DIBE_REG_RST 8'h00
`define DIBE_ROUNDS 5'd16
`define DIBE_KEY_BYTES 3'd7
`define DIBE_KEY_STEP_LAST 5'd2
`define DIBE_BYTE_STEP_LAST 5'd24
`define DIBE_WR_STEP 5'd23
`define DIBE_LOAD_STEP 5'd0
`define DIBE_CAP_STEP 5'd1
`endif

// File: rtl/dibe_pkg.sv
// shared types of the DES block engine
package dibe_pkg;
	typedef enum logic [4:0] {
		DIBE_IDLE = 5'b00001,
		DIBE_BEGIN = 5'b00010,
		DIBE_KEY = 5'b00100,
		DIBE_DATA = 5'b01000,
		DIBE_DONE = 5'b10000
	} dibe_state_type;
endpackage

// File: rtl/dibe_core.sv
// iterative single-DES forward cipher, one round per clock
`timescale 1ns/1ps
`include "dibe_consts.svh"
module dibe_core
	import dibe_pkg::*;
(
	input wire logic i_core_clk, // system clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_load, // take block and key
	input wire logic [63:0] i_block, // input block
	input wire logic [55:0] i_key, // key, no parity bits
	output logic [63:0] o_block // result, stable 16 edges after load
);
	localparam logic [511:0] IP_T = 512'h3a322a221a120a023c342c241c140c043e362e261e160e0640383028201810083931292119110901_3b332b231b130b033d352d251d150d053f372f271f170f07;
	localparam logic [511:0] FP_T = 512'h2808301038184020270f2f0f37173f1f2606_2e0e36163e1e25052d0d35153d1d24042c0c34143c1c23032b0b33133b1b22022a0a32123a1a2101290931113919;
	localparam logic [511:0] E_T = {384'h200102030405040506070809080_90a0b0c0d0c0d0e0f101110111213141514151617181918191a1b1c1d1c1d1e1f2001, 128'h0};
	localparam logic [511:0] P_T = {256'h1007141_51d0c1c11010f171a05121f0a0208180e201b0309130d1e06160b0419, 256'h0};
	localparam logic [511:0] PC1_T = {448'h393129211911090_13a322a221a120a023b332b231b130b033c342c243f372f271f170f073e362e261e160e063d352d251d150d051c140c04, 64'h0};
	localparam logic [511:0] PC2_T = {384'h0e110b180105031c0f06150a17130c041a081007_1b140d0229341f252f371e28332d21302c31273822352e2a32241d20, 128'h0};
	localparam logic [255:0] SB [8] = '{
		256'he4d12fb83a6c59070f74e2d1a6cb953841e8d62bfc973a50fc8249175b3ea06d,
		256'hf18e6b34972dc05a3d47f28ec01a69b50e7ba4d158c6932fd8a13f42b67c05e9,
		256'ha09e63f51dc7b428d709346a285ecbf1d6498f30b12c5ae71ad069874fe3b52c,
		256'h7de3069a1285bc4fd8b56f03472c1ae9a690cb7df13e52843f06a1d8945bc72e,
		256'h2c417ab6853fd0e9eb2c47d150fa3986421bad78f9c5630eb8c71e2d6f09a453,
		256'hc1af92680d34e75baf427c9561de0b389ef528c3704a1db6432c95fabe17608d,
		256'h4b2ef08d3c975a61d0b749a1e35c2f8614bdc37eaf6805926bd814a7950fe23c,
		256'hd2846fb1a93e50c71fd8a374c56b0e927b419ce206adf35821e74a8dfc90356b
	};
	logic [27:0] c, d, nc, nd;
	logic [31:0] l, r, fo;
	logic [4:0] rnd;
	logic [63:0] key64;
	logic [47:0] sub;
	logic sh;
	logic [63:0] pc1_out;

	// table entries count bits from 1 at the msb of a win-bit input
	function automatic logic [63:0] permute(input logic [63:0] v, input int win, input int wout,
		input logic [511:0] t);
		logic [63:0] o;
		o = '0;
		for (int i = 0; i < wout; i++) begin
			o[wout - 1 - i] = v[win - int'(t[511 - 8 * i -: 8])];
		end
		return o;
	endfunction

	function automatic logic [31:0] feistel(input logic [31:0] rv, input logic [47:0] k);
		logic [63:0] e;
		logic [47:0] x;
		logic [63:0] s;
		logic [5:0] b;
		logic [5:0] ix;
		e = permute({32'h0, rv}, 32, 48, E_T);
		x = e[47:0] ^ k;
		s = '0;
		for (int j = 0; j < 8; j++) begin
			b = x[47 - 6 * j -: 6];
			ix = {b[5], b[0], b[4:1]};
			s[31 - 4 * j -: 4] = SB[j][255 - 4 * int'(ix) -: 4];
		end
		s = permute(s, 32, 32, P_T);
		return s[31:0];
	endfunction

	// seven key bytes become the eight-byte form with zero parity bits
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_par
			assign key64[63 - 8 * g -: 8] = {i_key[55 - 7 * g -: 7], 1'b0};
		end
	endgenerate

	always_comb begin
		logic [63:0] pk;
		pk = '0;
		sh = (rnd == 5'd0) || (rnd == 5'd1) || (rnd == 5'd8) || (rnd == 5'd15);
		nc = sh ? {c[26:0], c[27]} : {c[25:0], c[27:26]};
		nd = sh ? {d[26:0], d[27]} : {d[25:0], d[27:26]};
		pk = permute({8'h00, nc, nd}, 56, 48, PC2_T);
		sub = pk[47:0];
		fo = feistel(r, sub);
	end

	assign pc1_out = permute(key64, 64, 56, PC1_T);
	assign o_block = permute({r, l}, 64, 64, FP_T);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			c <= '0;
			d <= '0;
			l <= '0;
			r <= '0;
			rnd <= `DIBE_ROUNDS;
		end else if (i_load) begin
			{c, d} <= pc1_out[55:0];
			{l, r} <= permute(i_block, 64, 64, IP_T);
			rnd <= 5'd0;
		end else if (rnd != `DIBE_ROUNDS) begin
			c <= nc;
			d <= nd;
			l <= r;
			r <= l ^ fo;
			rnd <= rnd + 5'd1;
		end
	end
endmodule

// File: rtl/dibe_top.sv
// DES in-place block engine: APB registers, RAM sequencer and byte feedback
// Overview of operation
// - one run handles 1 to 256 contiguous bytes; longer messages use several runs.
// - cipher works on 8-byte blocks; feedback modes allow any byte count.
// - key is seven RAM bytes from eight times the key location.
// - data starts at eight times the data location, low three bits zero.
// - each result byte is written back to the address it came from.
// - control bit 3 picks output feedback (0) or cipher feedback (1).
// - control bit 2 picks encryption (0) or decryption (1).
// - key reloads at run start only when control bit 4 is set.
// - completion sets control bit 5 until software clears it.
// - with bit 6 set, completion also sets the shared ADC interrupt flag.
// - hardware updates the IV during runs; software reloads it per message.
// - run lasts 2 + 25 per byte + 21 with key reload, uncontended.
// - RAM accesses share the processor port; contention stretches the run.
// - byte count zero means 256 bytes.
// - eight byte registers hold the IV; register n holds bits 8n+7..8n.
`timescale 1ns/1ps
`include "dibe_consts.svh"
module dibe_top
	import dibe_pkg::*;
(
	input wire logic i_core_clk, // system clock, 250 MHz
	input wire logic i_nrst, // async reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb access phase
	input wire logic i_pwrite, // apb write
	input wire logic [9:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, unmapped address
	output logic o_ram_req, // ram access request
	output logic o_ram_we, // ram write, else read
	output logic [15:0] o_ram_addr, // ram byte address
	output logic [7:0] o_ram_wdata, // ram write data
	input wire logic i_ram_gnt, // ram access done at this edge
	input wire logic [7:0] i_ram_rdata, // read data, cycle after grant
	input wire logic i_adc_irq, // adc event pulse
	output logic o_irq // shared interrupt line
);
	localparam logic [7:0] IV0 = `DIBE_IV0_IDX;
	localparam logic [7:0] IV4 = `DIBE_IV4_IDX;

	dibe_state_type state;
	logic [4:0] cnt;
	logic [2:0] kidx;
	logic [7:0] idx;
	logic run_start_busy;
	logic completion_flag;
	logic completion_irq_enable;
	logic key_reload_enable;
	logic feedback_mode_select;
	logic direction_select;
	logic reserved_triple_bit;
	logic [7:0] key_location;
	logic [7:0] data_location;
	logic [7:0] byte_count;
	logic [7:0] init_vector_byte [8];
	logic shared_adc_irq_flag;
	logic shared_adc_irq_enable;
	logic [55:0] key_hold;
	logic [7:0] din;
	logic [63:0] ks_block;
	logic [63:0] iv_vec;
	logic [7:0] ks;
	logic [7:0] fb;
	logic [7:0] last_idx;
	logic [7:0] aidx;
	logic apb_setup;
	logic apb_wr;
	logic aligned;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [3:0] wr_iv;
	logic stall;
	logic run_end;
	logic core_load;
	logic enter_key;
	logic enter_data;
	logic enter_wr;
	logic [2:0] key_nx;
	logic [7:0] data_nx;
	logic [15:0] key_base;
	logic [15:0] dat_base;

	// bit 3 flags an iv register, bits 2:0 give its byte number
	function automatic logic [3:0] iv_slot(input logic [7:0] ix);
		logic [3:0] s;
		s = 4'h0;
		if (ix[7:2] == IV0[7:2]) begin
			s = {2'b10, ix[1:0]};
		end else if (ix[7:2] == IV4[7:2]) begin
			s = {2'b11, ix[1:0]};
		end
		return s;
	endfunction

	assign apb_setup = i_psel & ~i_penable;
	assign apb_wr = i_psel & i_penable & i_pwrite & o_pready;
	assign aidx = i_paddr[9:2];
	assign aligned = (i_paddr[1:0] == 2'b00);
	assign wr_iv = aligned ? iv_slot(aidx) : 4'h0;

	// register n is byte n of the vector
	generate
		for (genvar n = 0; n < 8; n++) begin : g_iv
			assign iv_vec[8 * n + 7 -: 8] = init_vector_byte[n];
		end
	endgenerate

	assign last_idx = byte_count - 8'h01;
	assign key_base = {5'h00, key_location, 3'h0};
	assign dat_base = {5'h00, data_location, 3'h0};
	assign ks = ks_block[63:56];
	assign stall = o_ram_req & ~i_ram_gnt;

	always_comb begin
		fb = ks;
		if (feedback_mode_select) begin
			fb = direction_select ? din : din ^ ks;
		end
	end

	always_comb begin
		rd_hit = aligned;
		rd_byte = 8'h00;
		if (wr_iv[3]) begin
			rd_byte = init_vector_byte[wr_iv[2:0]];
		end else begin
			unique case (aidx)
				`DIBE_CTRL_IDX: rd_byte = {1'b0, completion_irq_enable, completion_flag,
					key_reload_enable, feedback_mode_select, direction_select,
					reserved_triple_bit, run_start_busy};
				`DIBE_KEYLOC_IDX: rd_byte = key_location;
				`DIBE_DATLOC_IDX: rd_byte = data_location;
				`DIBE_COUNT_IDX: rd_byte = byte_count;
				`DIBE_IRQ_STAT_IDX: rd_byte = {7'h00, shared_adc_irq_flag};
				`DIBE_IRQ_CLR_IDX: rd_byte = 8'h00;
				`DIBE_IRQ_EN_IDX: rd_byte = {7'h00, shared_adc_irq_enable};
				default: rd_hit = 1'b0;
			endcase
		end
		if (!aligned) begin
			rd_hit = 1'b0;
		end
	end

	// apb answers with one wait-free access phase
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= apb_setup;
			o_pslverr <= apb_setup & ~rd_hit;
			if (apb_setup) begin
				o_prdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// control register: key-reload, mode, direction and reserved bits frozen while a run is active; bits 5 and 6 stay writable
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			run_start_busy <= `DIBE_BIT_RST;
			completion_flag <= `DIBE_BIT_RST;
			completion_irq_enable <= `DIBE_BIT_RST;
			key_reload_enable <= `DIBE_BIT_RST;
			feedback_mode_select <= `DIBE_BIT_RST;
			direction_select <= `DIBE_BIT_RST;
			reserved_triple_bit <= `DIBE_BIT_RST;
		end else begin
			if (apb_wr && aligned && aidx == `DIBE_CTRL_IDX) begin
				completion_irq_enable <= i_pwdata[`DIBE_BIT_IE];
				completion_flag <= i_pwdata[`DIBE_BIT_DONE];
				if (!run_start_busy) begin
					key_reload_enable <= i_pwdata[`DIBE_BIT_KEYLD];
					feedback_mode_select <= i_pwdata[`DIBE_BIT_MODE];
					direction_select <= i_pwdata[`DIBE_BIT_DIR];
					reserved_triple_bit <= i_pwdata[`DIBE_BIT_RSVD];
				end
				if (i_pwdata[`DIBE_BIT_RUN]) begin
					run_start_busy <= 1'b1;
				end
			end
			if (run_end) begin
				run_start_busy <= 1'b0;
				completion_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			key_location <= `DIBE_REG_RST;
			data_location <= `DIBE_REG_RST;
			byte_count <= `DIBE_REG_RST;
		end else if (apb_wr && aligned && !run_start_busy) begin
			if (aidx == `DIBE_KEYLOC_IDX) begin
				key_location <= i_pwdata[7:0];
			end
			if (aidx == `DIBE_DATLOC_IDX) begin
				data_location <= i_pwdata[7:0];
			end
			if (aidx == `DIBE_COUNT_IDX) begin
				byte_count <= i_pwdata[7:0];
			end
		end
	end

	// iv: software owns it between runs, hardware shifts it during one
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int n = 0; n < 8; n++) begin
				init_vector_byte[n] <= `DIBE_REG_RST;
			end
		end else if (state == DIBE_DATA && cnt == `DIBE_BYTE_STEP_LAST) begin
			init_vector_byte[0] <= fb;
			for (int n = 1; n < 8; n++) begin
				init_vector_byte[n] <= init_vector_byte[n - 1];
			end
		end else if (apb_wr && wr_iv[3] && !run_start_busy) begin
			init_vector_byte[wr_iv[2:0]] <= i_pwdata[7:0];
		end
	end

	// shared interrupt flag: a new event wins over a clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			shared_adc_irq_flag <= `DIBE_BIT_RST;
			shared_adc_irq_enable <= `DIBE_BIT_RST;
			o_irq <= 1'b0;
		end else begin
			if (apb_wr && aligned && aidx == `DIBE_IRQ_CLR_IDX && i_pwdata[`DIBE_BIT_IRQ]) begin
				shared_adc_irq_flag <= 1'b0;
			end
			if (apb_wr && aligned && aidx == `DIBE_IRQ_EN_IDX) begin
				shared_adc_irq_enable <= i_pwdata[`DIBE_BIT_IRQ];
			end
			if ((run_end && completion_irq_enable) || i_adc_irq) begin
				shared_adc_irq_flag <= 1'b1;
			end
			o_irq <= shared_adc_irq_flag & shared_adc_irq_enable;
		end
	end

	// run sequencer; steps stall while a ram request waits
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= DIBE_IDLE;
			cnt <= 5'd0;
			kidx <= 3'd0;
			idx <= 8'h00;
		end else begin
			unique case (state)
				DIBE_IDLE: begin
					if (run_start_busy) begin
						state <= DIBE_BEGIN;
					end
				end
				DIBE_BEGIN: begin
					state <= key_reload_enable ? DIBE_KEY : DIBE_DATA;
					cnt <= 5'd0;
					kidx <= 3'd0;
					idx <= 8'h00;
				end
				DIBE_KEY: begin
					if (!stall) begin
						if (cnt == `DIBE_KEY_STEP_LAST) begin
							cnt <= 5'd0;
							if (kidx == `DIBE_KEY_BYTES - 3'd1) begin
								state <= DIBE_DATA;
							end else begin
								kidx <= kidx + 3'd1;
							end
						end else begin
							cnt <= cnt + 5'd1;
						end
					end
				end
				DIBE_DATA: begin
					if (!stall) begin
						if (cnt == `DIBE_BYTE_STEP_LAST) begin
							cnt <= 5'd0;
							if (idx == last_idx) begin
								state <= DIBE_DONE;
							end else begin
								idx <= idx + 8'h01;
							end
						end else begin
							cnt <= cnt + 5'd1;
						end
					end
				end
				DIBE_DONE: begin
					state <= DIBE_IDLE;
				end
				default: begin
					state <= DIBE_IDLE;
				end
			endcase
		end
	end

	assign enter_key = (state == DIBE_BEGIN && key_reload_enable) ||
		(state == DIBE_KEY && cnt == `DIBE_KEY_STEP_LAST && kidx != `DIBE_KEY_BYTES - 3'd1);
	assign enter_data = (state == DIBE_BEGIN && !key_reload_enable) ||
		(state == DIBE_KEY && cnt == `DIBE_KEY_STEP_LAST && kidx == `DIBE_KEY_BYTES - 3'd1) ||
		(state == DIBE_DATA && cnt == `DIBE_BYTE_STEP_LAST && idx != last_idx);
	assign enter_wr = state == DIBE_DATA && cnt == `DIBE_WR_STEP - 5'd1;
	assign key_nx = (state == DIBE_BEGIN) ? 3'd0 : kidx + 3'd1;
	assign data_nx = (state == DIBE_DATA) ? idx + 8'h01 : 8'h00;
	// ram port: a request holds until granted
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ram_req <= 1'b0;
			o_ram_we <= 1'b0;
			o_ram_addr <= 16'h0000;
			o_ram_wdata <= 8'h00;
		end else if (enter_key) begin
			o_ram_req <= 1'b1;
			o_ram_we <= 1'b0;
			o_ram_addr <= key_base + {13'h0000, key_nx};
		end else if (enter_data) begin
			o_ram_req <= 1'b1;
			o_ram_we <= 1'b0;
			o_ram_addr <= dat_base + {8'h00, data_nx};
		end else if (enter_wr) begin
			o_ram_req <= 1'b1;
			o_ram_we <= 1'b1;
			o_ram_wdata <= din ^ ks;
		end else if (i_ram_gnt) begin
			o_ram_req <= 1'b0;
			o_ram_we <= 1'b0;
		end
	end

	// key is kept across runs unless reloaded
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			key_hold <= 56'h0;
			din <= 8'h00;
		end else begin
			if (state == DIBE_KEY && cnt == `DIBE_CAP_STEP) begin
				key_hold <= {key_hold[47:0], i_ram_rdata};
			end
			if (state == DIBE_DATA && cnt == `DIBE_CAP_STEP) begin
				din <= i_ram_rdata;
			end
		end
	end
	assign core_load = state == DIBE_DATA && cnt == `DIBE_LOAD_STEP && !stall;
	assign run_end = state == DIBE_DATA && !stall && cnt == `DIBE_BYTE_STEP_LAST && idx == last_idx;

	dibe_core u_core (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_load(core_load),
		.i_block(iv_vec),
		.i_key(key_hold),
		.o_block(ks_block)
	);
endmodule

// File: verif/dibe_top_properties.sv
// port-level checks of the DES block engine, bound to its top module
`timescale 1ns/1ps
module dibe_properties (
	input wire logic i_core_clk, // system clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb access phase
	input wire logic [31:0] o_prdata, // apb read data
	input wire logic o_pready, // apb ready
	input wire logic o_pslverr, // apb error
	input wire logic o_ram_req, // ram request
	input wire logic o_ram_we, // ram write
	input wire logic [15:0] o_ram_addr, // ram byte address
	input wire logic [7:0] o_ram_wdata, // ram write data
	input wire logic i_ram_gnt // ram grant
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence ram_wait_s;
		o_ram_req && !i_ram_gnt;
	endsequence
	sequence wr_done_s;
		o_ram_req && o_ram_we && i_ram_gnt;
	endsequence
	pready_setup_a: assert property (setup_s |=> o_pready)
		else $error("ready missing after setup");
	pready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
		else $error("ready without setup");
	slverr_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("error outside access");
	prdata_width_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	ram_hold_a: assert property (ram_wait_s |=> o_ram_req && $stable(o_ram_addr) && $stable(o_ram_we))
		else $error("ram request changed while waiting");
	ram_wdata_a: assert property (ram_wait_s ##0 o_ram_we |=> $stable(o_ram_wdata))
		else $error("ram write data changed while waiting");
	ram_release_a: assert property (o_ram_req && i_ram_gnt |=> !o_ram_req)
		else $error("ram request held after grant");
	write_space_a: assert property (wr_done_s |=> (!(o_ram_req && o_ram_we))[*8])
		else $error("ram writes too close");
	addr_range_a: assert property (o_ram_req |-> o_ram_addr < 16'h0900)
		else $error("ram address out of reach");
endmodule
bind dibe_top dibe_properties u_props (.i_core_clk, .i_nrst, .i_psel, .i_penable, .o_prdata, .o_pready,
	.o_pslverr, .o_ram_req, .o_ram_we, .o_ram_addr, .o_ram_wdata, .i_ram_gnt);

// File: verif/dibe_ram_model.sv
// byte-wide shared data RAM with optional grant stalls from processor traffic
`timescale 1ns/1ps
module dibe_ram_model (
	input wire logic i_core_clk, // system clock
	input wire logic i_ram_req, // access request
	input wire logic i_ram_we, // write, else read
	input wire logic [15:0] i_ram_addr, // byte address
	input wire logic [7:0] i_ram_wdata, // write data
	input wire logic i_stall, // processor takes every other cycle
	output logic o_ram_gnt, // access done at this edge
	output logic [7:0] o_ram_rdata // read data, cycle after grant
);
	logic [7:0] mem [0:2047];
	logic wr_mark [0:2047];
	logic toggle = 1'b0;
	initial o_ram_rdata = 8'h00;
	assign o_ram_gnt = i_ram_req & ~(i_stall & toggle);
	always @(posedge i_core_clk) begin
		toggle <= ~toggle;
		if (o_ram_gnt && i_ram_we) begin
			mem[i_ram_addr[10:0]] <= i_ram_wdata;
			wr_mark[i_ram_addr[10:0]] <= 1'b1;
		end
		// data is valid one cycle only, then scrambled
		o_ram_rdata <= (o_ram_gnt && !i_ram_we) ? mem[i_ram_addr[10:0]] : ~o_ram_rdata;
	end
endmodule

// File: verif/dibe_top_tb.sv
// self-checking bench of the DES block engine with a shared RAM model
`timescale 1ns/1ps
`include "dibe_consts.svh"
module dibe_top_tb;
	import dibe_pkg::*;
	localparam int LIMIT = 70000;
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [9:0] i_paddr = 10'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic i_adc_irq = 1'b0;
	logic stall = 1'b0;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, o_ram_req, o_ram_we, i_ram_gnt, o_irq;
	logic [15:0] o_ram_addr;
	logic [7:0] o_ram_wdata, i_ram_rdata;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	dibe_top uut (.i_core_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
		.o_pslverr, .o_ram_req, .o_ram_we, .o_ram_addr, .o_ram_wdata, .i_ram_gnt, .i_ram_rdata, .i_adc_irq, .o_irq);
	dibe_ram_model ram (.i_core_clk, .i_ram_req(o_ram_req), .i_ram_we(o_ram_we), .i_ram_addr(o_ram_addr),
		.i_ram_wdata(o_ram_wdata), .i_stall(stall), .o_ram_gnt(i_ram_gnt), .o_ram_rdata(i_ram_rdata));
	always #2 i_core_clk = ~i_core_clk;
	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd,
		output logic err);
		int w = 0;
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= {idx, 2'b00};
		i_pwdata <= {24'h0, wd};
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		@(posedge i_core_clk);
		while (o_pready !== 1'b1 && w < 20) begin
			@(posedge i_core_clk);
			w++;
		end
		if (w == 20) n_mismatch++;
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		logic err;
		apb(1'b1, idx, wd, rd, err);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, idx, 8'h00, rd, err);
		chk(rd, {24'h0, exp});
	endtask
	// returns edges from the start write until the interrupt line is seen high
	task automatic run(input logic [7:0] ctl, input logic [7:0] kl, input logic [7:0] cnt, output int dur);
		wr(`DIBE_KEYLOC_IDX, kl);
		wr(`DIBE_DATLOC_IDX, 8'h20);
		wr(`DIBE_COUNT_IDX, cnt);
		for (int i = 0; i < 8; i++) begin
			wr(i < 4 ? `DIBE_IV0_IDX + 8'(i) : `DIBE_IV4_IDX + 8'(i - 4), 8'h5a + 8'(i));
		end
		for (int i = 0; i < 2048; i++) begin
			ram.wr_mark[i] = 1'b0;
		end
		wr(`DIBE_CTRL_IDX, ctl | 8'h41);
		dur = 1;
		while (o_irq !== 1'b1 && dur < 20000) begin
			@(posedge i_core_clk);
			dur++;
		end
		wr(`DIBE_IRQ_CLR_IDX, 8'h01);
	endtask
	task automatic s_regs;
		logic [31:0] rd;
		logic err;
		rdc(`DIBE_CTRL_IDX, `DIBE_REG_RST);
		rdc(`DIBE_KEYLOC_IDX, 8'h00);
		rdc(`DIBE_DATLOC_IDX, 8'h00);
		rdc(`DIBE_COUNT_IDX, 8'h00);
		rdc(`DIBE_IV4_IDX + 8'h03, 8'h00);
		apb(1'b0, 8'h00, 8'h00, rd, err);
		chk(err, 1'b1);
		wr(`DIBE_CTRL_IDX, 8'hde);
		rdc(`DIBE_CTRL_IDX, 8'h5e);
		wr(`DIBE_CTRL_IDX, 8'h00);
		wr(`DIBE_IV4_IDX + 8'h03, 8'ha7);
		rdc(`DIBE_IV4_IDX + 8'h03, 8'ha7);
		wr(`DIBE_IRQ_CLR_IDX, 8'h01);
		rdc(`DIBE_IRQ_CLR_IDX, 8'h00);
	endtask
	task automatic s_irq;
		wr(`DIBE_IRQ_EN_IDX, 8'h01);
		i_adc_irq <= 1'b1;
		@(posedge i_core_clk);
		i_adc_irq <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		chk(o_irq, 1'b1);
		wr(`DIBE_IRQ_EN_IDX, 8'h00);
		@(posedge i_core_clk);
		chk(o_irq, 1'b0);
		rdc(`DIBE_IRQ_STAT_IDX, 8'h01);
		wr(`DIBE_IRQ_CLR_IDX, 8'h01);
		rdc(`DIBE_IRQ_STAT_IDX, 8'h00);
		wr(`DIBE_IRQ_EN_IDX, 8'h01);
	endtask
	task automatic s_busy;
		logic [31:0] rd;
		logic err;
		int w = 0;
		wr(`DIBE_COUNT_IDX, 8'h02);
		wr(`DIBE_CTRL_IDX, 8'h01);
		rdc(`DIBE_CTRL_IDX, 8'h01);
		wr(`DIBE_CTRL_IDX, 8'h10);
		wr(`DIBE_COUNT_IDX, 8'h05);
		rdc(`DIBE_CTRL_IDX, 8'h01);
		rdc(`DIBE_COUNT_IDX, 8'h02);
		do begin
			apb(1'b0, `DIBE_CTRL_IDX, 8'h00, rd, err);
			w++;
		end while (rd[0] !== 1'b0 && w < 100);
		chk(rd, 32'h20);
		chk(o_irq, 1'b0);
		rdc(`DIBE_IRQ_STAT_IDX, 8'h00);
		wr(`DIBE_CTRL_IDX, 8'h00);
		rdc(`DIBE_CTRL_IDX, 8'h00);
	endtask
	// encrypt then decrypt in place; the second pass must restore the block
	task automatic s_crypt(input logic mode, input logic [7:0] cnt, input logic slow, input logic rekey);
		int nb = (cnt == 8'h00) ? 256 : int'(cnt);
		int dur;
		int bad = 0;
		int diff = 0;
		for (int i = 255; i < 513; i++) begin
			ram.mem[i] = 8'(i * 7 + 3);
		end
		stall <= slow;
		run({3'b000, 1'b1, mode, 3'b000}, 8'h10, cnt, dur);
		if (!slow) chk(dur, 25 + 25 * nb);
		else chk(dur > 25 + 25 * nb, 1'b1);
		chk({ram.wr_mark[255], ram.wr_mark[256], ram.wr_mark[255 + nb], ram.wr_mark[256 + nb]}, 4'b0110);
		for (int i = 256; i < 256 + nb; i++) begin
			if (ram.mem[i] !== 8'(i * 7 + 3)) diff++;
		end
		if (nb > 1) chk(diff > 0, 1'b1);
		for (int i = 0; i < 7; i++) begin
			ram.mem[16'h0240 + i] = ram.mem[16'h0080 + i];
			ram.mem[16'h0080 + i] = ~ram.mem[16'h0080 + i];
		end
		run({3'b000, rekey, mode, 3'b100}, 8'h48, cnt, dur);
		if (!slow) chk(dur, 4 + 21 * int'(rekey) + 25 * nb);
		for (int i = 255; i < 513; i++) begin
			if (ram.mem[i] !== 8'(i * 7 + 3)) bad++;
		end
		chk(bad, 0);
		stall <= 1'b0;
	endtask
	initial begin
		for (int i = 0; i < 2048; i++) begin
			ram.mem[i] = 8'(i * 13 + 1);
		end
		repeat (3) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		@(posedge i_core_clk);
		s_regs();
		s_irq();
		s_busy();
		s_crypt(1'b0, 8'd1, 1'b0, 1'b0);
		s_crypt(1'b1, 8'd11, 1'b0, 1'b1);
		s_crypt(1'b1, 8'd0, 1'b0, 1'b0);
		s_crypt(1'b0, 8'd9, 1'b1, 1'b1);
		stop_test();
	end
endmodule
